/* common/fso_pkg.sv */
/*
  Constants for the fill and halt instruction executor: opcode patterns,
  masks, data widths, status flag reset values and the cycle phase count.
  Assumes a 16-bit instruction word and an 8-bit data path.
*/
package fso_pkg;
  localparam int          DATA_W          = 8;
  localparam int          INSTR_W         = 16;
  localparam int          ADDR_W          = 8;
  // halt word: fixed leading bits, final bit set
  localparam logic [15:0] HALT_OPCODE     = 16'h0003;
  // fill word: 0010 101s ffff ffff
  localparam logic [15:0] FILL_MASK       = 16'hFE00;
  localparam logic [15:0] FILL_MATCH      = 16'h2A00;
  localparam int          FILL_SEL_BIT    = 8;
  localparam logic [7:0]  ALL_ONES        = 8'hFF;
  localparam logic        POWER_DOWN_RESET = 1'b1;
  localparam logic        TIMEOUT_RESET    = 1'b1;
  localparam int          PHASE_COUNT     = 4;
  localparam logic [1:0]  PHASE_LAST      = 2'h3;
  localparam logic [1:0]  PHASE_EXEC      = 2'h2;
endpackage

/* design/fso_phase_gen.sv */
/*
  Four-phase instruction cycle generator. One-cycle pulse on the last
  phase of each instruction cycle; assumes one system clock per phase.
*/
`timescale 1ns/10ps
`default_nettype none
module fso_phase_gen
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       run,
  output logic [1:0]      phase,
  output logic            cycle_end
);
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;

  always_comb
  begin
    phase_nxt = phase_r;
    if (run)
    begin
      phase_nxt = 2'(phase_r + 2'h1);
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_r <= 2'h0;
    end
    else
    begin
      phase_r <= phase_nxt;
    end
  end

  assign phase     = phase_r;
  assign cycle_end = run && (phase_r == fso_pkg::PHASE_LAST);
endmodule
`default_nettype wire

/* design/fso_exec.sv */
/*
  Executor for the fill-ones and halt instructions of an 8-bit core.
  Assumes the fetch stage presents instr_word with instr_valid held for a
  whole instruction cycle, and that wake logic raises wake to restart.
*/
`timescale 1ns/10ps
`default_nettype none
module fso_exec
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        wake,
  input  wire logic        wdt_wake,
  output logic             power_down_flag,
  output logic             timeout_flag,
  output logic             watchdog_clear,
  output logic             osc_run,
  output logic             fetch_enable,
  output logic             file_we,
  output logic [7:0]       file_addr,
  output logic [7:0]       file_wdata,
  output logic             working_we,
  output logic [7:0]       working_register
);
  typedef enum logic {FSO_RUN, FSO_HALT} fso_state_t;

  function automatic logic is_halt(input logic [15:0] w);
    is_halt = (w == fso_pkg::HALT_OPCODE);
  endfunction

  function automatic logic is_fill(input logic [15:0] w);
    is_fill = ((w & fso_pkg::FILL_MASK) == fso_pkg::FILL_MATCH);
  endfunction

  logic [1:0] phase;
  logic       cycle_end;
  fso_state_t state_r;
  fso_state_t state_nxt;
  logic       pdown_r;
  logic       pdown_nxt;
  logic       tmo_r;
  logic       tmo_nxt;
  logic       wdc_r;
  logic       wdc_nxt;
  logic       fwe_r;
  logic       fwe_nxt;
  logic [7:0] faddr_r;
  logic [7:0] faddr_nxt;
  logic       wwe_r;
  logic       wwe_nxt;
  logic [7:0] work_r;
  logic [7:0] work_nxt;
  logic       run_r;
  logic       run_nxt;
  logic       exec;

  fso_phase_gen u_phase
  (
    .clock     (clock),
    .reset_n   (reset_n),
    .run       (state_r == FSO_RUN),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // act once per instruction cycle, at the final phase
  assign exec = cycle_end && instr_valid;

  always_comb
  begin
    state_nxt = state_r;
    pdown_nxt = pdown_r;
    tmo_nxt   = tmo_r;
    wdc_nxt   = 1'b0;
    fwe_nxt   = 1'b0;
    faddr_nxt = faddr_r;
    wwe_nxt   = 1'b0;
    work_nxt  = work_r;
    unique case (state_r)
      FSO_RUN:
      begin
        if (exec && is_halt(instr_word))
        begin
          pdown_nxt = 1'b0;
          tmo_nxt   = 1'b1;
          wdc_nxt   = 1'b1;
          state_nxt = FSO_HALT;
        end
        else if (exec && is_fill(instr_word))
        begin
          // status flags untouched on fill
          fwe_nxt   = 1'b1;
          faddr_nxt = instr_word[7:0];
          if (!instr_word[fso_pkg::FILL_SEL_BIT])
          begin
            wwe_nxt  = 1'b1;
            work_nxt = fso_pkg::ALL_ONES;
          end
        end
      end
      FSO_HALT:
      begin
        if (wake)
        begin
          state_nxt = FSO_RUN;
          // watchdog wake clears the timeout flag
          if (wdt_wake)
          begin
            tmo_nxt = 1'b0;
          end
        end
      end
    endcase
    // oscillator gate registered so the output has no decode glitch
    run_nxt = (state_nxt == FSO_RUN);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= FSO_RUN;
      pdown_r <= fso_pkg::POWER_DOWN_RESET;
      tmo_r   <= fso_pkg::TIMEOUT_RESET;
      wdc_r   <= 1'b0;
      fwe_r   <= 1'b0;
      faddr_r <= 8'h00;
      wwe_r   <= 1'b0;
      work_r  <= 8'h00;
      run_r   <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      pdown_r <= pdown_nxt;
      tmo_r   <= tmo_nxt;
      wdc_r   <= wdc_nxt;
      fwe_r   <= fwe_nxt;
      faddr_r <= faddr_nxt;
      wwe_r   <= wwe_nxt;
      work_r  <= work_nxt;
      run_r   <= run_nxt;
    end
  end

  assign power_down_flag  = pdown_r;
  assign timeout_flag     = tmo_r;
  assign watchdog_clear   = wdc_r;
  // both stop together: a fetch with no clock would hang the bus
  assign osc_run          = run_r;
  assign fetch_enable     = run_r;
  assign file_we          = fwe_r;
  assign file_addr        = faddr_r;
  // only ones are ever written by this block
  assign file_wdata       = fso_pkg::ALL_ONES;
  assign working_we       = wwe_r;
  assign working_register = work_r;

  a_halt_pd_clear: assert property (@(posedge clock) disable iff (!reset_n)
    exec && state_r == FSO_RUN && is_halt(instr_word) |=> !power_down_flag)
    else $error("power-down flag not cleared by halt");
  a_halt_timeout_set: assert property (@(posedge clock) disable iff (!reset_n)
    exec && state_r == FSO_RUN && is_halt(instr_word) |=> timeout_flag)
    else $error("timeout flag not set by halt");
  a_halt_wdt_clear: assert property (@(posedge clock) disable iff (!reset_n)
    watchdog_clear |-> !osc_run && !power_down_flag)
    else $error("watchdog clear without halt entry");
  a_halt_osc_stop: assert property (@(posedge clock) disable iff (!reset_n)
    exec && state_r == FSO_RUN && is_halt(instr_word) |=> !osc_run && !fetch_enable)
    else $error("oscillator still running after halt");
  a_halt_decode_only: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(osc_run) |-> $past(is_halt(instr_word)) && $past(exec))
    else $error("halt entered on wrong opcode");
  a_fill_write: assert property (@(posedge clock) disable iff (!reset_n)
    exec && state_r == FSO_RUN && is_fill(instr_word)
    |=> file_we && file_addr == $past(instr_word[7:0])
        && working_we == !$past(instr_word[8]))
    else $error("fill write wrong");
  a_fill_flags_kept: assert property (@(posedge clock) disable iff (!reset_n)
    file_we |-> $stable(power_down_flag) && $stable(timeout_flag))
    else $error("fill changed status flags");
  a_fill_work_ones: assert property (@(posedge clock) disable iff (!reset_n)
    working_we |-> working_register == 8'hFF)
    else $error("working register not all ones");

  a_wdt_clear_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    exec && state_r == FSO_RUN && is_halt(instr_word)
    |=> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog clear not a single pulse on halt");
  a_wake_wdt_clear: assert property (@(posedge clock) disable iff (!reset_n)
    state_r == FSO_HALT && wake && wdt_wake
    |=> !timeout_flag && osc_run && fetch_enable)
    else $error("watchdog wake left timeout flag set");
  a_wake_plain_keep: assert property (@(posedge clock) disable iff (!reset_n)
    state_r == FSO_HALT && wake && !wdt_wake
    |=> timeout_flag && osc_run && fetch_enable)
    else $error("plain wake changed timeout flag");
  a_halt_held: assert property (@(posedge clock) disable iff (!reset_n)
    state_r == FSO_HALT && !wake
    |=> !osc_run && !fetch_enable)
    else $error("core left halt without wake");
  a_halt_no_write: assert property (@(posedge clock) disable iff (!reset_n)
    !fetch_enable
    |-> !file_we && !working_we && $stable(working_register))
    else $error("write while halted");
  a_other_word_ignored: assert property (@(posedge clock) disable iff (!reset_n)
    exec && !is_halt(instr_word) && !is_fill(instr_word)
    |=> osc_run && !watchdog_clear && !file_we && !working_we)
    else $error("unknown word acted on");
  a_fill_file_only: assert property (@(posedge clock) disable iff (!reset_n)
    exec && is_fill(instr_word) && instr_word[fso_pkg::FILL_SEL_BIT]
    |=> file_we && !working_we && $stable(working_register))
    else $error("fill with select set touched working register");
endmodule
`default_nettype wire

/* testbench/fso_exec_tb_top.sv */
/*
  Bench for the fill and halt executor: fills, halt, ignored work in halt,
  a watchdog wake and a stray word. Assumes fso_exec; inputs on falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module fso_exec_tb_top;
  logic        clock       = 1'b0;
  logic        reset_n     = 1'b0;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word  = 16'h0000;
  logic        wake        = 1'b0;
  logic        wdt_wake    = 1'b0;
  logic        pdn, tmo, wclr, osc, fen, fwe, wwe;
  logic [7:0]  fadr, fdat, wkr;
  int          bad_count   = 0;
  int          check_count = 0;
  int          cyc         = 0;
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end

  fso_exec DUT
  (
    .clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .wake(wake), .wdt_wake(wdt_wake),
    .power_down_flag(pdn), .timeout_flag(tmo), .watchdog_clear(wclr),
    .osc_run(osc), .fetch_enable(fen), .file_we(fwe), .file_addr(fadr),
    .file_wdata(fdat), .working_we(wwe), .working_register(wkr)
  );

  always #10 clock = ~clock;

  // guard against a hang; whole run is under a hundred cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_fill(input logic [15:0] w, input logic [7:0] wk);
    instr_word = w;
    instr_valid = 1'b1;
    @(negedge clock);
    for (int i = 0; i < 8 && fwe !== 1'b1; i++) @(negedge clock);
    `CHK("file_we", 1'b1, fwe)
    `CHK("file_addr", w[7:0], fadr)
    `CHK("file_wdata", 8'hFF, fdat)
    `CHK("working_we", ~w[8], wwe)
    `CHK("working_reg", wk, wkr)
    `CHK("flags", 2'h3, {pdn, tmo})
  endtask

  task automatic do_halt();
    instr_word = 16'h0003;
    instr_valid = 1'b1;
    @(negedge clock);
    for (int i = 0; i < 8 && wclr !== 1'b1; i++) @(negedge clock);
    `CHK("wd_clear", 1'b1, wclr)
    `CHK("power_down", 1'b0, pdn)
    `CHK("timeout", 1'b1, tmo)
    `CHK("run", 2'h0, {osc, fen})
    @(negedge clock);
    `CHK("wd_clear", 1'b0, wclr)
  endtask

  // halted core must not act on a fill word
  task automatic halt_ignores();
    instr_word = 16'h2A44;
    repeat (8)
    begin
      @(negedge clock);
      `CHK("file_we", 1'b0, fwe)
      `CHK("osc_run", 1'b0, osc)
    end
  endtask

  task automatic wd_wake();
    wake = 1'b1;
    wdt_wake = 1'b1;
    @(negedge clock);
    wake = 1'b0;
    wdt_wake = 1'b0;
    `CHK("osc_run", 1'b1, osc)
    `CHK("timeout", 1'b0, tmo)
  endtask

  // last bit clear is not the halt word
  task automatic stray_word();
    instr_word = 16'h0002;
    repeat (8)
    begin
      @(negedge clock);
      `CHK("wd_clear", 1'b0, wclr)
      `CHK("osc_run", 1'b1, osc)
    end
  endtask

  // wake not from the watchdog leaves the timeout flag alone
  task automatic plain_wake();
    wake = 1'b1;
    @(negedge clock);
    wake = 1'b0;
    `CHK("osc_run", 1'b1, osc)
    `CHK("timeout", 1'b1, tmo)
  endtask

  initial
  begin
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    `CHK("reset", 12'hE00, {pdn, tmo, osc, fwe, wkr})
    do_fill(16'h2B5A, 8'h00);
    do_fill(16'h2A00, 8'hFF);
    do_halt();
    halt_ignores();
    wd_wake();
    stray_word();
    do_halt();
    plain_wake();
    instr_valid = 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
